// >>> core/irqc_cfg.svh
/*
 Constants of the peripheral interrupt controller: register offsets,
 bit positions, reset values and vector addresses.
 Assumes it is included by the package and the design files by name.
*/
`ifndef IRQC_CFG_SVH
`define IRQC_CFG_SVH

// Register offsets
`define OFS_REQUEST 8'h16
`define OFS_ENABLE 8'h17
`define OFS_CORE_IRQ 8'h07
`define OFS_CORE_STATUS 8'h06
`define OFS_PORT_SNAP 8'h12

// Request and enable bit positions
`define B_PORT 7
`define B_TMR3 6
`define B_TMR2 5
`define B_TMR1 4
`define B_CAP2 3
`define B_CAP1 2
`define B_TX 1
`define B_RX 0

// Core interrupt status bit positions
`define B_PEND 7
`define B_T0CKI_F 6
`define B_T0_F 5
`define B_INT_F 4
`define B_PERIPH_GROUP_ENABLE 3
`define B_T0CKI_E 2
`define B_T0_E 1
`define B_INT_E 0

// Global disable position in the core status register
`define B_GLD 4

// Reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_CORE 4'h0
`define RST_FLAGS 3'h0

// Vector sources by priority index, 0 highest
`define V_INT 2'h0
`define V_T0 2'h1
`define V_T0CKI 2'h2
`define V_PERIPH 2'h3

// Vector addresses
`define VEC_INT 16'h0008
`define VEC_T0 16'h0010
`define VEC_T0CKI 16'h0018
`define VEC_PERIPH 16'h0020

`endif

// >>> core/irqc_pkg.sv
/*
 Types of the peripheral interrupt controller.
 Assumes the constants header sits beside it.
*/
`include "irqc_cfg.svh"

package irqc_pkg;

   // Whole state of the controller
   typedef struct packed {
      logic [7:0] req;        // Peripheral request flags
      logic [7:0] ena;        // Peripheral enables
      logic [3:0] core_en;    // Group and dedicated enables
      logic [2:0] core_flag;  // Dedicated flags: t0cki, t0, int
      logic glob_dis;         // Global disable
      logic [7:0] port_latch; // Last port value seen by software
      logic [7:0] port_s1;    // Port synchroniser, first stage
      logic [7:0] port_s2;    // Port synchroniser, second stage
      logic [3:0] pin_s1;     // cap2, cap1, t0cki, int: first stage
      logic [3:0] pin_s2;     // Second stage
      logic [3:0] pin_s3;     // Delayed copy for edge detection
      logic t3_hit;           // Timer3 equalled its period
      logic t2_hit;           // Timer2 equalled its period
      logic t1_hit;           // Timer1 equalled its period
      logic t12_hit;          // Paired timer equalled its period
      logic [7:0] rdata;      // Read data
      logic vec_load;         // Vector load pulse
      logic [15:0] vec_addr;  // Vector address
      logic stack_push;       // Push pulse
      logic [15:0] push_addr; // Pushed return address
   } irqc_state_t;

endpackage

// >>> core/vector_select.sv
/*
 Fixed-priority selector of the four interrupt vectors.
 Assumes pending requests arrive already masked, index 0 highest.
*/
`timescale 1ns/100ps
`include "irqc_cfg.svh"

module vector_select (
   // Masked requests, bit 0 highest priority
   input wire logic [3:0] pend,
   // Selection
   output logic valid,
   output logic [1:0] idx,
   output logic [15:0] addr
);
   import irqc_pkg::*;

   // Vector address of a source index
   function automatic logic [15:0] vec_of(input logic [1:0] i);
      unique case (i)
         `V_INT: vec_of = `VEC_INT;
         `V_T0: vec_of = `VEC_T0;
         `V_T0CKI: vec_of = `VEC_T0CKI;
         `V_PERIPH: vec_of = `VEC_PERIPH;
      endcase
   endfunction

   always_comb begin
      valid = |pend;
      if (pend[0]) begin
         idx = `V_INT;
      end else if (pend[1]) begin
         idx = `V_T0;
      end else if (pend[2]) begin
         idx = `V_T0CKI;
      end else begin
         idx = `V_PERIPH;
      end
      addr = vec_of(idx);
   end

endmodule

// >>> core/periph_irq_ctrl.sv
/*
 Peripheral interrupt controller: request and enable registers, the
 dedicated core flags, global disable and vectoring towards the core.
 Assumes timers, serial buffers and the core sequencer run on mclk;
 port and pin inputs come from outside and are synchronised here.
*/
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`include "irqc_cfg.svh"

module periph_irq_ctrl (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Pins from outside
   input wire logic [7:0] change_monitored_port,
   input wire logic capture2_input_pin,
   input wire logic capture1_input_pin,
   input wire logic ext_int_pin,
   input wire logic timer0_clock_pin,
   // Timer events and values, same clock
   input wire logic timer0_overflow,
   input wire logic timer3_overflow,
   input wire logic capture1_or_period_select,
   input wire logic timer1_wide_mode,
   input wire logic [15:0] timer3_count,
   input wire logic [15:0] timer3_period_pair,
   input wire logic [7:0] timer1_count,
   input wire logic [7:0] timer2_count,
   input wire logic [7:0] timer1_period,
   input wire logic [7:0] timer2_period,
   // Serial buffer levels, same clock
   input wire logic serial_tx_full,
   input wire logic serial_rx_full,
   // Core sequencer
   input wire logic instr_boundary,
   input wire logic return_from_irq_instr,
   input wire logic [15:0] return_addr,
   output logic vector_load,
   output logic [15:0] vector_addr,
   output logic stack_push,
   output logic [15:0] stack_push_addr,
   output logic global_irq_disable
);
   import irqc_pkg::*;

   // Present and next state. Everything the block remembers lives in
   // this one struct, so the reset list below and the next-state code
   // cover the same fields and nothing can be left unregistered.
   irqc_state_t st;
   irqc_state_t next_st;

   // Combinational helpers
   logic [7:0] live_req;       // Request flags as seen now
   logic [7:0] set_req;        // Hardware set requests this cycle
   logic periph_pending_flag;  // Masked peripheral pending
   logic [3:0] pend;           // Masked requests to the selector
   logic sel_valid;            // Some request pending
   logic [1:0] sel_idx;        // Winning source
   logic [15:0] sel_addr;      // Winning vector
   logic take;                 // Accept an interrupt now
   logic [3:0] pin_rise;       // Rising edges of synchronised pins
   logic [15:0] pair_count;    // Paired timer value
   logic [15:0] pair_period;   // Paired period value

   // Rollover to zero after a period match in the previous cycle.
   // The match is remembered one cycle, so a count that merely
   // passes through zero without a match sets nothing.
   function automatic logic rolled(input logic hit,
                                   input logic zero);
      rolled = hit & zero;
   endfunction

   // Register read decode. The request register shows stored flags
   // together with events of this cycle, so software never misses a
   // set that lands in the same cycle as its read.
   function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                         input irqc_state_t s,
                                         input logic [7:0] rq,
                                         input logic pe);
      rd_mux = `RST_BYTE;
      unique case (a)
         `OFS_REQUEST: rd_mux = rq;
         `OFS_ENABLE: rd_mux = s.ena;
         `OFS_CORE_IRQ: rd_mux = {pe, s.core_flag, s.core_en};
         `OFS_CORE_STATUS: rd_mux[`B_GLD] = s.glob_dis;
         `OFS_PORT_SNAP: rd_mux = s.port_s2;
         default: rd_mux = `RST_BYTE;
      endcase
   endfunction

   // Priority selector of the four vectors
   vector_select u_sel (
      .pend(pend),
      .valid(sel_valid),
      .idx(sel_idx),
      .addr(sel_addr)
   );

   // Outputs straight from the state
   assign reg_rdata = st.rdata;
   assign vector_load = st.vec_load;
   assign vector_addr = st.vec_addr;
   assign stack_push = st.stack_push;
   assign stack_push_addr = st.push_addr;
   assign global_irq_disable = st.glob_dis;

   // Event detection and pending logic.
   // Pins are only looked at after two synchroniser stages; the third
   // stage exists only to find rising edges, so metastable values
   // never reach the flags.
   always_comb begin
      pin_rise = st.pin_s2 & ~st.pin_s3;
      pair_count = {timer1_count, timer2_count};
      pair_period = {timer1_period, timer2_period};
      set_req = `RST_BYTE;
      set_req[`B_PORT] = |(st.port_s2 ^ st.port_latch);
      if (capture1_or_period_select) begin
         set_req[`B_TMR3] = timer3_overflow;
      end else begin
         set_req[`B_TMR3] = rolled(st.t3_hit, timer3_count == `RST_WORD);
      end
      set_req[`B_TMR2] = rolled(st.t2_hit, timer2_count == `RST_BYTE);
      if (timer1_wide_mode) begin
         set_req[`B_TMR1] = rolled(st.t12_hit, pair_count == `RST_WORD);
      end else begin
         set_req[`B_TMR1] = rolled(st.t1_hit, timer1_count == `RST_BYTE);
      end
      set_req[`B_CAP2] = pin_rise[3];
      set_req[`B_CAP1] = pin_rise[2];
      live_req = st.req | set_req;
      live_req[`B_TX] = ~serial_tx_full;
      live_req[`B_RX] = serial_rx_full;
      periph_pending_flag = |(live_req & st.ena);
      pend[`V_PERIPH] = periph_pending_flag & st.core_en[`B_PERIPH_GROUP_ENABLE];
      pend[`V_INT] = st.core_flag[0] & st.core_en[`B_INT_E];
      pend[`V_T0] = st.core_flag[1] & st.core_en[`B_T0_E];
      pend[`V_T0CKI] = st.core_flag[2] & st.core_en[`B_T0CKI_E];
      take = instr_boundary & ~st.glob_dis & sel_valid;
   end

   // Next state.
   // Order matters here: software writes first, then hardware sets,
   // then the vectoring clear, so an event in the same cycle as a
   // write or a vector clear is never lost.
   always_comb begin
      next_st = st;
      // Synchronisers, two stages before use
      next_st.port_s1 = change_monitored_port;
      next_st.port_s2 = st.port_s1;
      next_st.pin_s1 = {capture2_input_pin, capture1_input_pin,
                        timer0_clock_pin, ext_int_pin};
      next_st.pin_s2 = st.pin_s1;
      next_st.pin_s3 = st.pin_s2;
      // Period matches remembered for the rollover test
      next_st.t3_hit = timer3_count == timer3_period_pair;
      next_st.t2_hit = timer2_count == timer2_period;
      next_st.t1_hit = timer1_count == timer1_period;
      next_st.t12_hit = pair_count == pair_period;
      // Read data stand one cycle after the strobe
      next_st.rdata = `RST_BYTE;
      if (reg_rd) begin
         next_st.rdata = rd_mux(reg_addr, st, live_req,
                                periph_pending_flag);
         // Reading the port ends the mismatch
         if (reg_addr == `OFS_PORT_SNAP) begin
            next_st.port_latch = st.port_s2;
         end
      end
      // Software writes
      if (reg_wr) begin
         unique case (reg_addr)
            `OFS_REQUEST: begin
               next_st.req = reg_wdata;
            end
            `OFS_ENABLE: begin
               next_st.ena = reg_wdata;
            end
            `OFS_CORE_IRQ: begin
               next_st.core_en = reg_wdata[3:0];
               next_st.core_flag = reg_wdata[6:4];
            end
            `OFS_CORE_STATUS: begin
               next_st.glob_dis = reg_wdata[`B_GLD];
            end
            default: begin
               next_st.req = st.req;
            end
         endcase
      end
      // hardware set wins over a write
      next_st.req = next_st.req | set_req;
      // Serial bits are levels, not stored events
      next_st.req[`B_TX] = 1'b0;
      next_st.req[`B_RX] = 1'b0;
      // Dedicated flags: set wins over a write
      next_st.core_flag[0] = next_st.core_flag[0] | pin_rise[0];
      next_st.core_flag[1] = next_st.core_flag[1] | timer0_overflow;
      next_st.core_flag[2] = next_st.core_flag[2] | pin_rise[1];
      if (return_from_irq_instr) begin
         next_st.glob_dis = 1'b0;
      end
      // Vectoring outputs are single pulses
      next_st.vec_load = 1'b0;
      next_st.stack_push = 1'b0;
      if (take) begin
         next_st.glob_dis = 1'b1;
         next_st.vec_load = 1'b1;
         next_st.vec_addr = sel_addr;
         next_st.stack_push = 1'b1;
         next_st.push_addr = return_addr;
         unique case (sel_idx)
            `V_INT: next_st.core_flag[0] = pin_rise[0];
            `V_T0: next_st.core_flag[1] = timer0_overflow;
            `V_T0CKI: next_st.core_flag[2] = pin_rise[1];
            `V_PERIPH: next_st.core_flag = next_st.core_flag;
         endcase
      end
   end

   // State register.
   // Reset is synchronous; every field gets a constant, and global
   // disable comes up set so nothing is taken before software has
   // cleared stale flags and chosen its enables.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         st.req <= `RST_BYTE;
         st.ena <= `RST_BYTE;
         st.core_en <= `RST_CORE;
         st.core_flag <= `RST_FLAGS;
         st.glob_dis <= 1'b1;
         st.port_latch <= `RST_BYTE;
         st.port_s1 <= `RST_BYTE;
         st.port_s2 <= `RST_BYTE;
         st.pin_s1 <= `RST_CORE;
         st.pin_s2 <= `RST_CORE;
         st.pin_s3 <= `RST_CORE;
         st.t3_hit <= 1'b0;
         st.t2_hit <= 1'b0;
         st.t1_hit <= 1'b0;
         st.t12_hit <= 1'b0;
         st.rdata <= `RST_BYTE;
         st.vec_load <= 1'b0;
         st.vec_addr <= `RST_WORD;
         st.stack_push <= 1'b0;
         st.push_addr <= `RST_WORD;
      end else begin
         st <= next_st;
      end
   end

endmodule

// >>> verif/periph_irq_ctrl_props.sv
/*
 Checker of the interrupt controller's port behaviour.
 Assumes it is bound to periph_irq_ctrl and sees only its ports.
*/
`timescale 1ns/100ps
`include "irqc_cfg.svh"

module periph_irq_ctrl_props (
   // Clock, reset and register port
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Serial buffer levels
   input wire logic serial_tx_full,
   input wire logic serial_rx_full,
   // Core sequencer side
   input wire logic instr_boundary,
   input wire logic return_from_irq_instr,
   input wire logic [15:0] return_addr,
   input wire logic vector_load,
   input wire logic [15:0] vector_addr,
   input wire logic stack_push,
   input wire logic [15:0] stack_push_addr,
   input wire logic global_irq_disable
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   property p_rst; $rose(rstn) |-> global_irq_disable; endproperty
   a_rst: assert property (p_rst)
      else $error("disable clear after reset");

   property p_take; vector_load |-> global_irq_disable && stack_push;
   endproperty
   a_take: assert property (p_take)
      else $error("take without disable or push");

   property p_push; vector_load |-> stack_push_addr == $past(return_addr);
   endproperty
   a_push: assert property (p_push)
      else $error("wrong pushed address");

   property p_vec; vector_load |->
      vector_addr inside {`VEC_INT, `VEC_T0, `VEC_T0CKI, `VEC_PERIPH};
   endproperty
   a_vec: assert property (p_vec)
      else $error("vector outside the four");

   property p_when; vector_load |->
      $past(instr_boundary) && !$past(global_irq_disable);
   endproperty
   a_when: assert property (p_when)
      else $error("take off boundary or while disabled");

   property p_pulse; vector_load |=> !vector_load && !stack_push;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("vector pulse too long");

   property p_ret; return_from_irq_instr |=>
      !global_irq_disable || vector_load;
   endproperty
   a_ret: assert property (p_ret)
      else $error("return left disable set");

   property p_hold; global_irq_disable && !return_from_irq_instr &&
      !(reg_wr && reg_addr == `OFS_CORE_STATUS) |=> global_irq_disable;
   endproperty
   a_hold: assert property (p_hold)
      else $error("disable dropped by itself");

   property p_serial; reg_rd && reg_addr == `OFS_REQUEST |=>
      reg_rdata[1:0] == {!$past(serial_tx_full), $past(serial_rx_full)};
   endproperty
   a_serial: assert property (p_serial)
      else $error("serial flags wrong");
endmodule

bind periph_irq_ctrl periph_irq_ctrl_props periph_irq_ctrl_props_i (
   .mclk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
   .serial_tx_full, .serial_rx_full, .instr_boundary,
   .return_from_irq_instr, .return_addr, .vector_load, .vector_addr,
   .stack_push, .stack_push_addr, .global_irq_disable);

// >>> verif/core_seq_model.sv
/*
 Core sequencer stand-in: instruction boundaries, return address and
 return-from-interrupt. Assumes it runs on the block's mclk.
*/
`timescale 1ns/100ps

module core_seq_model (
   // Clock, reset and bench controls
   input wire logic mclk,
   input wire logic rstn,
   input wire logic slow,
   input wire logic ret_req,
   // Controller side
   input wire logic vector_load,
   input wire logic [15:0] vector_addr,
   output logic instr_boundary,
   output logic return_from_irq_instr,
   output logic [15:0] return_addr
);
   logic [1:0] phase; // Cycle within a slow instruction
   logic ret_pend; // Return waiting for a boundary

   // Boundaries every cycle, or every third when slow
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         phase <= 2'h0;
         ret_pend <= 1'b0;
         instr_boundary <= 1'b0;
         return_from_irq_instr <= 1'b0;
         return_addr <= 16'h0100;
      end else begin
         phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
         instr_boundary <= !slow || phase == 2'h2;
         // Return issued only in the cycle after an instruction boundary
         return_from_irq_instr <= ret_pend && instr_boundary;
         if (ret_req) begin
            ret_pend <= 1'b1;
         end else if (instr_boundary) begin
            ret_pend <= 1'b0;
         end
         // Program counter jumps to the vector when taken
         if (vector_load) begin
            return_addr <= vector_addr;
         end else if (instr_boundary) begin
            return_addr <= return_addr + 16'h0001;
         end
      end
   end
endmodule

// >>> verif/periph_irq_ctrl_tb.sv
/*
 Self-checking bench of the interrupt controller.
 Assumes core_seq_model and the bound checker are compiled before it.
*/
`timescale 1ns/100ps
`include "irqc_cfg.svh"

module periph_irq_ctrl_tb;
   logic mclk, rstn, reg_wr, reg_rd, slow, ret_req;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, change_monitored_port;
   logic capture2_input_pin, capture1_input_pin, ext_int_pin;
   logic timer0_clock_pin, timer0_overflow, timer3_overflow;
   logic capture1_or_period_select, timer1_wide_mode;
   logic serial_tx_full, serial_rx_full, instr_boundary;
   logic return_from_irq_instr, vector_load, stack_push;
   logic global_irq_disable;
   logic [15:0] timer3_count, timer3_period_pair, return_addr;
   logic [15:0] vector_addr, stack_push_addr;
   logic [7:0] timer1_count, timer2_count, timer1_period, timer2_period;
   int n_errors = 0, n_checks = 0, cyc = 0, takes = 0;
   // Request bit expected from each event
   localparam int ebit[8] = '{7, 6, 5, 4, 3, 2, 6, 4};

   periph_irq_ctrl periph_irq_ctrl_i (.mclk, .rstn, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .change_monitored_port,
      .capture2_input_pin, .capture1_input_pin, .ext_int_pin,
      .timer0_clock_pin, .timer0_overflow, .timer3_overflow,
      .capture1_or_period_select, .timer1_wide_mode, .timer3_count,
      .timer3_period_pair, .timer1_count, .timer2_count, .timer1_period,
      .timer2_period, .serial_tx_full, .serial_rx_full, .instr_boundary,
      .return_from_irq_instr, .return_addr, .vector_load, .vector_addr,
      .stack_push, .stack_push_addr, .global_irq_disable);
   core_seq_model core_seq_model_i (.mclk, .rstn, .slow, .ret_req,
      .vector_load, .vector_addr, .instr_boundary,
      .return_from_irq_instr, .return_addr);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Cycle ceiling and count of vector takes
   always @(posedge mclk) begin
      cyc++;
      if (vector_load === 1'b1) takes++;
      if (cyc == 20000) begin
         n_errors++;
         close_out();
      end
   end

   task close_out;
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // Read; data stand in the cycle after the strobe
   task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk({8'h00, reg_rdata & m}, {8'h00, e & m});
   endtask

   // Raise peripheral event k, then return to idle
   task fire(input int k);
      @(posedge mclk);
      capture1_or_period_select <= (k != 6);
      timer1_wide_mode <= (k == 7);
      @(posedge mclk);
      case (k)
         0: change_monitored_port <= 8'h01;
         1: timer3_overflow <= 1'b1;
         2: timer2_count <= 8'h05;
         3: timer1_count <= 8'h05;
         4: capture2_input_pin <= 1'b1;
         5: capture1_input_pin <= 1'b1;
         6: timer3_count <= 16'h0105;
         default: {timer1_count, timer2_count} <= 16'h0505;
      endcase
      @(posedge mclk);
      timer3_overflow <= 1'b0;
      {timer3_count, timer1_count, timer2_count} <= 32'h0;
      @(posedge mclk);
      {timer3_count, timer1_count, timer2_count} <= 32'h0001_0101;
      {capture2_input_pin, capture1_input_pin} <= 2'b00;
   endtask

   // Wait for a vector load and check its address
   task take(input logic [15:0] e);
      for (int i = 0; i < 40 && vector_load !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      chk({15'h0, vector_load}, 16'h0001);
      chk(vector_addr, e);
      chk({15'h0, stack_push}, 16'h0001);
      chk({15'h0, global_irq_disable}, 16'h0001);
   endtask

   task ret;
      @(posedge mclk);
      ret_req <= 1'b1;
      @(posedge mclk);
      ret_req <= 1'b0;
   endtask

   initial begin
      {rstn, reg_wr, reg_rd, slow, ret_req, reg_addr, reg_wdata} = '0;
      {change_monitored_port, capture2_input_pin, capture1_input_pin} = '0;
      {ext_int_pin, timer0_clock_pin, timer0_overflow} = '0;
      {timer3_overflow, timer1_wide_mode, serial_rx_full} = '0;
      {capture1_or_period_select, serial_tx_full} = 2'b11;
      {timer3_count, timer1_count, timer2_count} = 32'h0001_0101;
      {timer3_period_pair, timer1_period, timer2_period} = 32'h0105_0505;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      rd(`OFS_CORE_STATUS, 8'h10, 8'hff);
      rd(`OFS_REQUEST, 8'h00, 8'hff);
      for (int i = 0; i < 8; i++) begin
         wr(`OFS_ENABLE, 8'h01 << i);
         rd(`OFS_ENABLE, 8'h01 << i, 8'hff);
      end
      wr(8'h30, 8'hff);
      rd(8'h30, 8'h00, 8'hff);
      for (int k = 0; k < 8; k++) begin
         fire(k);
         repeat (5) @(posedge mclk);
         rd(`OFS_REQUEST, 8'h01 << ebit[k], (k == 7) ? 8'hdf : 8'hff);
         if (k == 0) rd(`OFS_PORT_SNAP, 8'h01, 8'hff);
         wr(`OFS_REQUEST, 8'h00);
         rd(`OFS_REQUEST, 8'h00, 8'hff);
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         {serial_tx_full, serial_rx_full} <= i[1:0];
         rd(`OFS_REQUEST, {6'h0, !i[1], i[0]}, 8'hff);
      end
      @(posedge mclk);
      {serial_tx_full, serial_rx_full} <= 2'b10;
      wr(`OFS_REQUEST, 8'h00);
      wr(`OFS_ENABLE, 8'h08);
      wr(`OFS_CORE_IRQ, 8'h07);
      @(posedge mclk);
      {ext_int_pin, timer0_clock_pin, timer0_overflow} <= 3'b111;
      capture2_input_pin <= 1'b1;
      @(posedge mclk);
      timer0_overflow <= 1'b0;
      repeat (6) @(posedge mclk);
      rd(`OFS_CORE_IRQ, 8'hf7, 8'hff);
      wr(`OFS_CORE_STATUS, 8'h00);
      take(`VEC_INT);
      ret();
      take(`VEC_T0);
      slow <= 1'b1;
      ret();
      take(`VEC_T0CKI);
      ret();
      repeat (12) @(posedge mclk);
      #1 chk({15'h0, global_irq_disable}, 16'h0000);
      chk(16'(takes), 16'h0003);
      rd(`OFS_CORE_IRQ, 8'h87, 8'hff);
      wr(`OFS_CORE_IRQ, 8'h0f);
      take(`VEC_PERIPH);
      rd(`OFS_REQUEST, 8'h08, 8'hff);
      wr(`OFS_REQUEST, 8'h00);
      ret();
      repeat (12) @(posedge mclk);
      chk(16'(takes), 16'h0004);
      close_out();
   end
endmodule
